/* File: hdl/cts_pkg.sv */
// Constants, types and register map of the CAN transceiver fault supervisor.
// Assumes a single 20 MHz clock shared by both ends.
package cts_pkg;
	localparam int CTS_CLK_MHZ = 20;
	// Plain default timeouts in microseconds
	localparam int CTS_CLAMP_US = 1000;
	localparam int CTS_TXD_US   = 1000;
	localparam int CTS_RXREC_US = 50;
	localparam int CTS_CLAMP_CYC = CTS_CLAMP_US * CTS_CLK_MHZ;
	localparam int CTS_TXD_CYC   = CTS_TXD_US * CTS_CLK_MHZ;
	localparam int CTS_RXREC_CYC = CTS_RXREC_US * CTS_CLK_MHZ;
	localparam int CTS_CNT_W     = 16;
	localparam int CTS_ECHO_DLY  = 4;

	typedef enum logic [1:0] {CTS_M_OFF, CTS_M_WAKE, CTS_M_NORMAL, CTS_M_RXONLY} cts_mode_t;

	localparam logic [1:0] CTS_OP_MODE = 2'h0;
	localparam logic [1:0] CTS_OP_MASK = 2'h1;
	localparam logic [1:0] CTS_OP_CLR  = 2'h2;
	localparam logic [1:0] CTS_OP_RAIL = 2'h3;

	localparam int CTS_DG_W      = 7;
	localparam int CTS_DG_CLAMP  = 0;
	localparam int CTS_DG_TXRX   = 1;
	localparam int CTS_DG_OT     = 2;
	localparam int CTS_DG_RXREC  = 3;
	localparam int CTS_DG_BUS    = 4;
	localparam int CTS_DG_TXDGND = 5;
	localparam int CTS_DG_UV     = 6;

	localparam logic [CTS_DG_W-1:0] CTS_MASK_RST = 7'h00;
	localparam logic [CTS_DG_W-1:0] CTS_DG_RST   = 7'h00;

	localparam logic [7:0] CTS_A_CMD  = 8'h00;
	localparam logic [7:0] CTS_A_CTRL = 8'h04;
	localparam logic [7:0] CTS_A_STAT = 8'h08;
	localparam int CTS_CMD_OP_LSB  = 0;
	localparam int CTS_CMD_ARG_LSB = 8;
	localparam int CTS_CTRL_TXD    = 0;
	localparam int CTS_CTRL_AUTO   = 1;
	localparam int CTS_CTRL_ECHO   = 2;
	localparam int CTS_ST_INTN     = 8;
	localparam int CTS_ST_RXD      = 9;
	localparam int CTS_ST_ECHO     = 10;
	localparam int CTS_ST_BUSY     = 11;
	localparam logic [2:0] CTS_CTRL_RST = 3'h1;
endpackage

/* File: hdl/cts_if.sv */
// Link between the transceiver supervisor and its host controller.
// Stands for the TxD and RxD pins, the parallel command strobe with op and argument, the diagnostic flags and the interrupt pin.
`timescale 1ns/100ps
`default_nettype none
interface cts_if;
	import cts_pkg::*;
	logic                txd;
	logic                rxd;
	logic                cmd_valid;
	logic [1:0]          cmd_op;
	logic [7:0]          cmd_arg;
	logic [CTS_DG_W-1:0] diag;
	logic                int_n;
	modport dev (input txd, cmd_valid, cmd_op, cmd_arg, output rxd, diag, int_n);
	modport host (output txd, cmd_valid, cmd_op, cmd_arg, input rxd, diag, int_n);
endinterface
`default_nettype wire

/* File: hdl/cts_dev.sv */
// Device end: fault supervision of the CAN transceiver cell.
// Assumes bus, pin readback and fault detector inputs synchronous to clk.
// Behaviour
// [R1] Long dominant bus forces receive-only, flags clamp
// [R2] Clamp reported in diagnostics, interrupt unless masked
// [R3] Receive-only holds until host commands normal
// [R4] TxD-RxD short detected and reported
// [R5] TxD-RxD short pulls interrupt low unless masked
// [R6] Short inhibits transmitter until host command
// [R7] Host should cut supply rail on short
// [R8] Overtemperature deactivates transceiver, mode kept
// [R9] After cooling, wait TxD rising edge
// [R10] RxD stuck recessive with traffic disables transmitter
// [R11] Stuck-recessive lockout cleared only by command
// [R12] Undervoltage from rail monitors; host may switch off
// [R13] Bus line short sets flag, interrupt
// [R14] Bus line short leaves mode unchanged
// [R15] Host detects CANH-CANL short by echo
// [R16] Split stabilizer on in normal, receive-only
// [R17] Long dominant TxD stops driver until active
// [R18] All faults reported; timeout as TxD ground
// [R19] Receive-only: driver off, reception continues
// [R20] Timeouts are parameterised clock counters
`timescale 1ns/100ps
`default_nettype none
module cts_dev
	import cts_pkg::*;
#(
	parameter int CLAMP_CYC = CTS_CLAMP_CYC,
	parameter int TXD_CYC   = CTS_TXD_CYC,
	parameter int RXREC_CYC = CTS_RXREC_CYC
) (
	input  wire logic clk,
	input  wire logic reset_n,
	cts_if.dev        lnk,
	input  wire logic bus_dom,
	input  wire logic rxd_pin_rec,
	input  wire logic txrx_short,
	input  wire logic overtemp,
	input  wire logic bus_line_fault,
	input  wire logic rail_uv,
	output var  logic tx_dom,
	output var  logic split_en,
	output var  logic rail_en
);
	localparam int CMAX = 2 ** CTS_CNT_W - 1;
	localparam logic [CTS_CNT_W-1:0] CLAMP_N = CTS_CNT_W'(CLAMP_CYC);
	localparam logic [CTS_CNT_W-1:0] TXD_N   = CTS_CNT_W'(TXD_CYC);
	localparam logic [CTS_CNT_W-1:0] RXREC_N = CTS_CNT_W'(RXREC_CYC);
	localparam logic [CTS_CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [CTS_CNT_W-1:0] CNT_ZERO = 16'h0000;

	generate
		if (CLAMP_CYC < 1 || CLAMP_CYC > CMAX || TXD_CYC < 1 || TXD_CYC > CMAX ||
			RXREC_CYC < 1 || RXREC_CYC > CMAX) begin : g_bad
			$error("cts_dev: timeout count out of counter range");
		end
	endgenerate

	typedef struct packed {
		cts_mode_t            mode;
		logic                 lk_clamp;
		logic                 lk_short;
		logic                 lk_txto;
		logic                 lk_rxrec;
		logic                 ot_off;
		logic                 ot_wait;
		logic                 txd_prev;
		logic [CTS_CNT_W-1:0] dom_cnt;
		logic [CTS_CNT_W-1:0] txd_cnt;
		logic [CTS_CNT_W-1:0] rec_cnt;
		logic [CTS_DG_W-1:0]  diag;
		logic [CTS_DG_W-1:0]  mask;
		logic                 rail;
		logic                 int_n;
		logic                 rxd;
		logic                 tx_dom;
		logic                 split;
	} cts_dev_st_t;

	cts_dev_st_t q;
	cts_dev_st_t d;
	logic        active;
	logic        tx_ok;

	always_comb begin
		d = q;
		d.txd_prev = lnk.txd;
		// Host commands first, so hardware events below win
		if (lnk.cmd_valid) begin
			case (lnk.cmd_op)
				CTS_OP_MODE: begin
					d.mode = cts_mode_t'(lnk.cmd_arg[1:0]);
					if (d.mode == CTS_M_NORMAL) begin
						d.lk_clamp = 1'b0; // R3
						d.lk_short = 1'b0; // R6
						d.lk_txto = 1'b0; // R17
						d.lk_rxrec = 1'b0; // R11
						d.rec_cnt = CNT_ZERO;
					end
				end
				CTS_OP_MASK: d.mask = lnk.cmd_arg[CTS_DG_W-1:0];
				CTS_OP_CLR: d.diag = q.diag & ~lnk.cmd_arg[CTS_DG_W-1:0];
				CTS_OP_RAIL: d.rail = lnk.cmd_arg[0];
				default: d.mode = q.mode;
			endcase
		end
		// Dominant bus clamp
		if (!bus_dom) begin
			d.dom_cnt = CNT_ZERO; // R20
		end else if (q.dom_cnt != CLAMP_N) begin
			d.dom_cnt = q.dom_cnt + CNT_ONE; // R20
		end
		if (bus_dom && q.dom_cnt == CLAMP_N - CNT_ONE) begin
			d.lk_clamp = 1'b1; // R1
			d.mode = CTS_M_RXONLY; // R1
			d.diag[CTS_DG_CLAMP] = 1'b1; // R2
		end
		// TxD dominant timeout
		if (lnk.txd) begin
			d.txd_cnt = CNT_ZERO; // R20
		end else if (q.txd_cnt != TXD_N) begin
			d.txd_cnt = q.txd_cnt + CNT_ONE;
		end
		if (!lnk.txd && q.txd_cnt == TXD_N - CNT_ONE) begin
			d.lk_txto = 1'b1; // R17
			d.diag[CTS_DG_TXDGND] = 1'b1; // R18
		end
		// RxD stuck recessive while the bus carries traffic
		if (!rxd_pin_rec) begin
			d.rec_cnt = CNT_ZERO;
		end else if (bus_dom && q.rec_cnt != RXREC_N) begin
			d.rec_cnt = q.rec_cnt + CNT_ONE;
		end
		if (rxd_pin_rec && bus_dom && q.rec_cnt == RXREC_N - CNT_ONE) begin
			d.lk_rxrec = 1'b1; // R10
			d.diag[CTS_DG_RXREC] = 1'b1; // R18
		end
		if (txrx_short) begin
			d.lk_short = 1'b1; // R6
			d.mode = CTS_M_RXONLY; // R6
			d.diag[CTS_DG_TXRX] = 1'b1; // R4
		end
		// Overtemperature leaves the mode untouched
		if (overtemp) begin
			d.ot_off = 1'b1; // R8
			d.ot_wait = 1'b1; // R9
			d.diag[CTS_DG_OT] = 1'b1; // R18
		end else begin
			d.ot_off = 1'b0; // R8
			if (q.ot_wait && !q.txd_prev && lnk.txd) begin
				d.ot_wait = 1'b0; // R9
			end
		end
		if (bus_line_fault) begin
			d.diag[CTS_DG_BUS] = 1'b1; // R13 R14
		end
		if (rail_uv) begin
			d.diag[CTS_DG_UV] = 1'b1; // R12
		end
		active = d.rail && !d.ot_off && (d.mode == CTS_M_NORMAL || d.mode == CTS_M_RXONLY);
		tx_ok = active && d.mode == CTS_M_NORMAL && !d.ot_wait && !d.lk_clamp &&
			!d.lk_short && !d.lk_txto && !d.lk_rxrec; // R19
		d.tx_dom = tx_ok && !lnk.txd;
		d.rxd = active ? !bus_dom : 1'b1; // R19
		d.split = d.rail && (d.mode == CTS_M_NORMAL || d.mode == CTS_M_RXONLY); // R16
		d.int_n = ~|(d.diag & ~d.mask); // R2 R5 R13
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '{mode: CTS_M_OFF, lk_clamp: 1'b0, lk_short: 1'b0, lk_txto: 1'b0,
				lk_rxrec: 1'b0, ot_off: 1'b0, ot_wait: 1'b0, txd_prev: 1'b1,
				dom_cnt: CNT_ZERO, txd_cnt: CNT_ZERO, rec_cnt: CNT_ZERO,
				diag: CTS_DG_RST, mask: CTS_MASK_RST, rail: 1'b1, int_n: 1'b1,
				rxd: 1'b1, tx_dom: 1'b0, split: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign lnk.rxd = q.rxd;
	assign lnk.diag = q.diag;
	assign lnk.int_n = q.int_n;
	assign tx_dom = q.tx_dom;
	assign split_en = q.split;
	assign rail_en = q.rail;
endmodule
`default_nettype wire

/* File: hdl/cts_host.sv */
// Host end: APB slave that turns register writes into transceiver commands.
// Assumes an APB master on clk and the device end joined through cts_if.
`timescale 1ns/100ps
`default_nettype none
module cts_host
	import cts_pkg::*;
#(
	parameter int ECHO_DLY = CTS_ECHO_DLY
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	cts_if.host              lnk,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr
);
	generate
		if (ECHO_DLY < 1 || ECHO_DLY > 8) begin : g_bad
			$error("cts_host: ECHO_DLY must be 1 to 8");
		end
	endgenerate

	typedef struct packed {
		logic [2:0]          ctrl;
		logic                cmd_v;
		logic [1:0]          cmd_op;
		logic [7:0]          cmd_arg;
		logic [7:0]          hist;
		logic                echo_err;
		logic                fault_prev;
		logic                auto_pend;
		logic [31:0]         rdata;
		logic                rdy;
		logic                err;
	} cts_host_st_t;

	cts_host_st_t q;
	cts_host_st_t d;
	logic         acc;
	logic         hit;
	logic         fault;

	always_comb begin
		d = q;
		d.cmd_v = 1'b0;
		d.rdy = 1'b0;
		acc = psel && penable && q.rdy;
		hit = paddr == CTS_A_CMD || paddr == CTS_A_CTRL || paddr == CTS_A_STAT;
		if (psel && !penable) begin
			d.rdy = 1'b1;
			d.err = !hit;
			d.rdata = 32'h0000_0000;
			case (paddr)
				CTS_A_CTRL: d.rdata[2:0] = q.ctrl;
				CTS_A_STAT: begin
					d.rdata[CTS_DG_W-1:0] = lnk.diag;
					d.rdata[CTS_ST_INTN] = lnk.int_n;
					d.rdata[CTS_ST_RXD] = lnk.rxd;
					d.rdata[CTS_ST_ECHO] = q.echo_err;
					d.rdata[CTS_ST_BUSY] = q.auto_pend;
				end
				default: d.rdata = 32'h0000_0000;
			endcase
		end
		if (acc && pwrite && paddr == CTS_A_CMD) begin
			d.cmd_v = 1'b1;
			d.cmd_op = pwdata[CTS_CMD_OP_LSB +: 2];
			d.cmd_arg = pwdata[CTS_CMD_ARG_LSB +: 8];
		end
		if (acc && pwrite && paddr == CTS_A_CTRL) begin
			d.ctrl = pwdata[2:0];
		end
		if (acc && pwrite && paddr == CTS_A_STAT && pwdata[CTS_ST_ECHO]) begin
			d.echo_err = 1'b0;
		end
		// Rail cut on pin short or undervoltage, when enabled
		fault = lnk.diag[CTS_DG_TXRX] || lnk.diag[CTS_DG_UV];
		d.fault_prev = fault;
		if (q.ctrl[CTS_CTRL_AUTO] && fault && !q.fault_prev) begin
			d.auto_pend = 1'b1; // R7 R12
		end
		if (q.auto_pend && !d.cmd_v && !q.cmd_v) begin
			d.cmd_v = 1'b1; // R7
			d.cmd_op = CTS_OP_RAIL;
			d.cmd_arg = 8'h00;
			d.auto_pend = 1'b0;
		end
		// Echo check: txd held dominant ECHO_DLY cycles must come back dominant
		d.hist = {q.hist[6:0], q.ctrl[CTS_CTRL_TXD]};
		if (q.ctrl[CTS_CTRL_ECHO] && q.hist[ECHO_DLY-1:0] == '0 && lnk.rxd) begin
			d.echo_err = 1'b1; // R15
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '{ctrl: CTS_CTRL_RST, cmd_v: 1'b0, cmd_op: CTS_OP_MODE,
				cmd_arg: 8'h00, hist: 8'hff, echo_err: 1'b0, fault_prev: 1'b0,
				auto_pend: 1'b0, rdata: 32'h0000_0000, rdy: 1'b0, err: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign lnk.txd = q.ctrl[CTS_CTRL_TXD];
	assign lnk.cmd_valid = q.cmd_v;
	assign lnk.cmd_op = q.cmd_op;
	assign lnk.cmd_arg = q.cmd_arg;
	assign prdata = q.rdata;
	assign pready = q.rdy;
	assign pslverr = q.err;
endmodule
`default_nettype wire

/* File: bench/cts_props.sv */
// Assertions on the link between host and device ends.
// Assumes one clock; the bench places it beside the link.
`timescale 1ns/100ps
`default_nettype none
module cts_props
	import cts_pkg::*;
#(
	parameter int TXD_CYC = CTS_TXD_CYC
) (
	input wire logic                clk,
	input wire logic                reset_n,
	input wire logic                txd,
	input wire logic                cmd_valid,
	input wire logic [1:0]          cmd_op,
	input wire logic [7:0]          cmd_arg,
	input wire logic [CTS_DG_W-1:0] diag,
	input wire logic                int_n
);
	logic [6:0] mask_q;
	logic [6:0] keep;
	int         cnt_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	assign keep = diag & ~((cmd_valid && cmd_op == CTS_OP_CLR) ? cmd_arg[6:0] : 7'h00);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mask_q <= 7'h00;
			cnt_q  <= 0;
		end else begin
			if (cmd_valid && cmd_op == CTS_OP_MASK)
				mask_q <= cmd_arg[6:0];
			cnt_q <= txd ? 0 : cnt_q + 1;
		end
	end
	sequence s_unmasked;
		(|(diag & ~mask_q)) [*2];
	endsequence
	sequence s_mask_all;
		cmd_valid && cmd_op == CTS_OP_MASK && cmd_arg[6:0] == 7'h7f;
	endsequence
	a_diag_sticky: assert property (1'b1 |=> (diag & $past(keep)) == $past(keep))
		else $error("flag dropped without clear");
	a_int_low: assert property (s_unmasked |-> !int_n)
		else $error("int_n high with unmasked flag");
	a_int_high: assert property ((diag == 7'h00) [*2] |-> int_n)
		else $error("int_n low with no flag");
	a_int_cause: assert property (!int_n |-> (diag | $past(diag)) != 7'h00)
		else $error("int_n low without cause");
	a_mask_gate: assert property (s_mask_all |-> ##[1:2] int_n)
		else $error("int_n low after full mask");
	a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
		else $error("command strobe too long");
	a_txd_early: assert property ($rose(diag[CTS_DG_TXDGND]) |-> cnt_q >= TXD_CYC - 1)
		else $error("txd timeout flagged early");
	a_txd_late: assert property (cnt_q == TXD_CYC + 2 |-> diag[CTS_DG_TXDGND])
		else $error("txd timeout not flagged");
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Bench: both ends joined, APB master, bus and fault stimulus.
// Assumes package, link, both ends and checker compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import cts_pkg::*;
	localparam int CLAMP = 30, TXDC = 20, RXRC = 8;
	logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, ext = 0, stuck = 0;
	logic        bus_dom = 0, pin_rec = 0, short_f = 0, hot = 0, line_f = 0, uv = 0;
	logic        pready, pslverr, tx_dom, split_en, rail_en;
	logic [7:0]  paddr = 8'h00, m;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [64:0] exp_q[$];
	int          errors = 0, checks = 0, seed;
	cts_if lnk();
	cts_dev #(.CLAMP_CYC(CLAMP), .TXD_CYC(TXDC), .RXREC_CYC(RXRC)) u_cts_dev(.clk(clk),
		.reset_n(reset_n), .lnk(lnk), .bus_dom(bus_dom), .rxd_pin_rec(pin_rec),
		.txrx_short(short_f), .overtemp(hot), .bus_line_fault(line_f), .rail_uv(uv),
		.tx_dom(tx_dom), .split_en(split_en), .rail_en(rail_en));
	cts_host u_cts_host(.clk(clk), .reset_n(reset_n), .lnk(lnk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	cts_props #(.TXD_CYC(TXDC)) u_cts_props(.clk(clk), .reset_n(reset_n), .txd(lnk.txd),
		.cmd_valid(lnk.cmd_valid), .cmd_op(lnk.cmd_op), .cmd_arg(lnk.cmd_arg),
		.diag(lnk.diag), .int_n(lnk.int_n));
	task automatic conclude();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input string what, input logic [32:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, d};
		@(posedge clk) penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		{psel, penable} <= 2'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] msk, e, input logic err = 1'h0);
		exp_q.push_back({err, msk, e & msk});
		apb(1'h0, a, 32'h0);
	endtask
	task automatic st(input logic [6:0] d, input logic i);
		rd(CTS_A_STAT, 32'h17f, {23'h0, i, 1'h0, d});
	endtask
	task automatic cmd(input logic [1:0] op, input logic [7:0] arg);
		apb(1'h1, CTS_A_CMD, {16'h0, arg, 6'h0, op});
	endtask
	task automatic tx(input logic b);
		apb(1'h1, CTS_A_CTRL, {31'h0, b});
	endtask
	task automatic dom(input logic e);
		wt(2);
		check("tx_dom", tx_dom, e);
	endtask
	initial forever #25 clk = ~clk;
	// Bus follows the driver or outside traffic; pin readback may be stuck
	always @(posedge clk) begin
		bus_dom <= ext | tx_dom;
		pin_rec <= lnk.rxd | stuck;
	end
	always @(posedge clk)
		if (psel && penable && pready && !pwrite) begin
			check("read", {pslverr, prdata & exp_q[0][63:32]}, exp_q[0][64:32] & 33'h100000000 | exp_q[0][31:0]);
			void'(exp_q.pop_front());
		end
	initial begin
		#(5000 * 50);
		errors++;
		conclude();
	end
	initial begin
		seed = $urandom(32'h2c79);
		wt(4);
		reset_n <= 1'h1;
		st(7'h00, 1'h1);
		rd(8'h0c, 32'hffffffff, 32'h0, 1'h1);
		for (int k = 0; k < 4; k++) begin
			cmd(CTS_OP_MODE, k[7:0]);
			wt(2);
			check("split_en", split_en, k >= 2);
		end
		ext <= 1'h1;
		tx(1'h0);
		dom(1'h0);
		check("rxd", lnk.rxd, 1'h0);
		ext <= 1'h0;
		tx(1'h1);
		$display("modes done");
		cmd(CTS_OP_MODE, 8'h2);
		ext <= 1'h1;
		wt(CLAMP + 4);
		ext <= 1'h0;
		st(7'h01, 1'h0);
		tx(1'h0);
		dom(1'h0);
		cmd(CTS_OP_MODE, 8'h2);
		dom(1'h1);
		tx(1'h1);
		cmd(CTS_OP_CLR, 8'h7f);
		st(7'h00, 1'h1);
		$display("clamp done");
		short_f <= 1'h1;
		wt(3);
		short_f <= 1'h0;
		st(7'h02, 1'h0);
		tx(1'h0);
		dom(1'h0);
		cmd(CTS_OP_MODE, 8'h2);
		cmd(CTS_OP_CLR, 8'h7f);
		dom(1'h1);
		tx(1'h1);
		$display("short done");
		m = {1'h0, 7'($urandom)};
		cmd(CTS_OP_MASK, 8'h7f);
		{line_f, uv} <= 2'h3;
		wt(2);
		{line_f, uv} <= 2'h0;
		st(7'h50, 1'h1);
		cmd(CTS_OP_MASK, m);
		st(7'h50, m[4] & m[6]);
		tx(1'h0);
		dom(1'h1);
		tx(1'h1);
		cmd(CTS_OP_MASK, 8'h0);
		cmd(CTS_OP_CLR, 8'h7f);
		$display("bus fault done");
		hot <= 1'h1;
		tx(1'h0);
		dom(1'h0);
		check("split_en", split_en, 1'h1);
		hot <= 1'h0;
		dom(1'h0);
		tx(1'h1);
		tx(1'h0);
		dom(1'h1);
		tx(1'h1);
		cmd(CTS_OP_CLR, 8'h7f);
		$display("overtemp done");
		tx(1'h0);
		wt(TXDC + 4);
		rd(CTS_A_STAT, 32'h20, 32'h20);
		dom(1'h0);
		tx(1'h1);
		cmd(CTS_OP_MODE, 8'h2);
		cmd(CTS_OP_CLR, 8'h7f);
		st(7'h00, 1'h1);
		$display("timeout done");
		{stuck, ext} <= 2'h3;
		wt(RXRC + 4);
		{stuck, ext} <= 2'h0;
		st(7'h08, 1'h0);
		tx(1'h0);
		dom(1'h0);
		cmd(CTS_OP_MODE, 8'h2);
		dom(1'h1);
		tx(1'h1);
		$display("stuck done");
		cmd(CTS_OP_CLR, 8'h7f);
		rd(CTS_A_CTRL, 32'hffffffff, 32'h1);
		rd(CTS_A_CMD, 32'hffffffff, 32'h0);
		cmd(CTS_OP_RAIL, 8'h0);
		wt(2);
		check("rail_en", rail_en, 1'h0);
		check("split_en", split_en, 1'h0);
		tx(1'h0);
		dom(1'h0);
		tx(1'h1);
		cmd(CTS_OP_RAIL, 8'h1);
		wt(2);
		check("rail_en", rail_en, 1'h1);
		apb(1'h1, CTS_A_CTRL, 32'h3);
		short_f <= 1'h1;
		wt(3);
		short_f <= 1'h0;
		wt(4);
		check("rail_en", rail_en, 1'h0);
		rd(CTS_A_STAT, 32'hb02, 32'h202);
		tx(1'h1);
		cmd(CTS_OP_RAIL, 8'h1);
		cmd(CTS_OP_MODE, 8'h2);
		cmd(CTS_OP_CLR, 8'h7f);
		$display("rail done");
		apb(1'h1, CTS_A_CTRL, 32'h4);
		wt(6);
		apb(1'h1, CTS_A_CTRL, 32'h5);
		rd(CTS_A_STAT, 32'h400, 32'h0);
		cmd(CTS_OP_MODE, 8'h3);
		apb(1'h1, CTS_A_CTRL, 32'h4);
		wt(6);
		apb(1'h1, CTS_A_CTRL, 32'h5);
		rd(CTS_A_STAT, 32'h400, 32'h400);
		apb(1'h1, CTS_A_STAT, 32'h400);
		rd(CTS_A_STAT, 32'h400, 32'h0);
		tx(1'h1);
		cmd(CTS_OP_MODE, 8'h2);
		$display("echo done");
		conclude();
	end
endmodule
`default_nettype wire
